//--- hw/rpl_control.sv
// read-protection level controller
// option byte storage is outside; this block holds the active level and sequences erases
// the eeprom, flash and backup erase engines each answer with their own done pulse
`timescale 1ns/1ps
`default_nettype none
module rpl_control (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] boot_byte,
    input wire logic boot_load,
    input wire logic wr_req,
    input wire logic [7:0] wr_byte,
    input wire logic [2:0] erase_done,
    output logic wr_ack,
    output logic wr_refused,
    output logic [2:0] erase_start,
    output logic [7:0] read_protect_option,
    output logic [1:0] level,
    output logic access_open,
    output logic debug_open,
    output logic busy
);

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    rpl_pkg::rpl_level_t cur_lvl;
    rpl_pkg::rpl_level_t req_lvl;
    rpl_pkg::rpl_state_t state_q;
    logic [7:0] opt_q;
    logic [7:0] pend_q;
    logic [rpl_pkg::RPL_N_MEM-1:0] done_q;
    logic [rpl_pkg::RPL_N_MEM-1:0] done_all;
    logic idle;
    logic cur_open;
    logic cur_locked;
    logic req_open;
    logic req_locked;
    logic take;
    logic refuse;
    logic erase_need;
    logic launch;
    logic finish;
    logic erase_run;

    // ----------------------------------------------------------------
    // access gate
    // ----------------------------------------------------------------
    // shared by the read and the debug output
    function automatic logic gate_open(
        input logic allowed,
        input logic running,
        input logic was_busy
    );
        // lags busy by a cycle, so the new level is already shown when access opens
        return allowed && !running && !was_busy;
    endfunction

    assign idle = (state_q == rpl_pkg::RPL_ST_IDLE);
    assign cur_lvl = rpl_pkg::rpl_decode(opt_q);
    assign req_lvl = rpl_pkg::rpl_decode(wr_byte);
    assign cur_open = (cur_lvl == rpl_pkg::RPL_LVL0);
    assign cur_locked = (cur_lvl == rpl_pkg::RPL_LVL2);
    assign req_open = (req_lvl == rpl_pkg::RPL_LVL0);
    assign req_locked = (req_lvl == rpl_pkg::RPL_LVL2);
    assign take = wr_req && idle;
    assign refuse = cur_locked && !req_locked;
    // defect kept: any level 0 write not refused at level 2 erases, even from level 0
    assign erase_need = req_open && !refuse;
    assign launch = take && erase_need;

    // ----------------------------------------------------------------
    // erase bookkeeping
    // ----------------------------------------------------------------
    assign done_all = done_q | erase_done;
    assign finish = (state_q == rpl_pkg::RPL_ST_WAIT) && (done_all == rpl_pkg::RPL_ALL_DONE);
    assign erase_run = !idle || launch;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= rpl_pkg::RPL_ST_IDLE;
        end else begin
            case (state_q)
                rpl_pkg::RPL_ST_IDLE: begin
                    if (launch) begin
                        state_q <= rpl_pkg::RPL_ST_ERASE;
                    end
                end
                rpl_pkg::RPL_ST_ERASE: begin
                    state_q <= rpl_pkg::RPL_ST_WAIT;
                end
                rpl_pkg::RPL_ST_WAIT: begin
                    if (finish) begin
                        state_q <= rpl_pkg::RPL_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= rpl_pkg::RPL_ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pending byte and done collection
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_q <= rpl_pkg::RPL_BYTE_RESET;
        end else if (launch) begin
            pend_q <= wr_byte;
        end
    end

    // collected from the erase state on, so an early done pulse is not lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done_q <= '0;
        end else if (idle) begin
            done_q <= '0;
        end else begin
            done_q <= done_all;
        end
    end

    // ----------------------------------------------------------------
    // active option byte
    // ----------------------------------------------------------------
    // a non-erasing write in the same cycle as a boot load is acked but lost; boot precedes software
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            opt_q <= rpl_pkg::RPL_BYTE_RESET;
        end else if (boot_load && idle) begin
            opt_q <= boot_byte;
        end else if (take && !refuse && !erase_need) begin
            opt_q <= wr_byte;
        end else if (finish) begin
            opt_q <= pend_q;
        end
    end

    // ----------------------------------------------------------------
    // request answers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ack <= 1'b0;
        end else begin
            wr_ack <= take && !refuse;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_refused <= 1'b0;
        end else begin
            wr_refused <= take && refuse;
        end
    end

    // all three memories start together; their done pulses may come apart
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            erase_start <= '0;
        end else begin
            erase_start <= launch ? rpl_pkg::RPL_ALL_DONE : '0;
        end
    end

    // ----------------------------------------------------------------
    // level view
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            read_protect_option <= rpl_pkg::RPL_BYTE_RESET;
        end else begin
            read_protect_option <= opt_q;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level <= rpl_pkg::RPL_LVL1;
        end else begin
            level <= cur_lvl;
        end
    end

    // ----------------------------------------------------------------
    // erase status and access gates
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= erase_run;
        end
    end

    // access held shut while erasing, so protected content never leaks
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            access_open <= 1'b0;
        end else begin
            access_open <= gate_open(cur_open, erase_run, busy);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            debug_open <= 1'b0;
        end else begin
            debug_open <= gate_open(!cur_locked, erase_run, busy);
        end
    end

endmodule
`default_nettype wire

//--- hw/rpl_pkg.sv
// constants and types for the read-protection level control block
// assumes a single 125 MHz clock and a synchronous active-high reset
//
// Function
// - three protection levels exist: 0 is open, 1 protects, 2 locks out debug and readout.
// - a request that raises the level is taken only while the sequencer is idle and never erases anything.
// - at level 2 every request for a lower level is refused.
// - lowering from level 1 to level 0 mass-erases data EEPROM, program Flash and backup registers.
// - the option byte value 0xAA requests level 0 and is decoded as level 0.
// - writing the level 0 value while already at level 0 still performs the mass erase (defect).
package rpl_pkg;

    // ----------------------------------------------------------------
    // option byte encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] RPL_BYTE_LVL0 = 8'hAA;
    localparam logic [7:0] RPL_BYTE_LVL2 = 8'hCC;

    typedef enum logic [1:0] {
        RPL_LVL0 = 2'b00,
        RPL_LVL1 = 2'b01,
        RPL_LVL2 = 2'b10
    } rpl_level_t;

    typedef enum logic [1:0] {
        RPL_ST_IDLE = 2'b00,
        RPL_ST_ERASE = 2'b01,
        RPL_ST_WAIT = 2'b10
    } rpl_state_t;

    // erase completion bits: eeprom, flash, backup
    localparam int RPL_N_MEM = 3;
    localparam logic [2:0] RPL_ALL_DONE = 3'h7;

    // unprogrammed option byte is the level 1 default
    localparam logic [7:0] RPL_BYTE_RESET = 8'h55;

    function automatic rpl_level_t rpl_decode(input logic [7:0] b);
        if (b == RPL_BYTE_LVL0) begin
            return RPL_LVL0;
        end else if (b == RPL_BYTE_LVL2) begin
            return RPL_LVL2;
        end else begin
            return RPL_LVL1;
        end
    endfunction

endpackage

//--- testbench/rpl_props.sv
// assertion checker on the rpl_control ports
// bound into every rpl_control instance
`timescale 1ns/1ps
`default_nettype none
module rpl_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic boot_load,
    input wire logic wr_req,
    input wire logic wr_ack,
    input wire logic wr_refused,
    input wire logic busy,
    input wire logic access_open,
    input wire logic debug_open,
    input wire logic [7:0] wr_byte,
    input wire logic [7:0] read_protect_option,
    input wire logic [2:0] erase_done,
    input wire logic [2:0] erase_start,
    input wire logic [1:0] level
);
    logic [2:0] got_q;
    wire logic go = !busy && wr_req && !boot_load;
    wire logic l2 = level == rpl_pkg::RPL_LVL2;
    wire logic b0 = wr_byte == rpl_pkg::RPL_BYTE_LVL0;
    wire logic b2 = wr_byte == rpl_pkg::RPL_BYTE_LVL2;
    wire logic fin = (got_q | erase_done) == rpl_pkg::RPL_ALL_DONE;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // done pulses arrive apart, so collect them
    always_ff @(posedge clock) got_q <= busy ? got_q | erase_done : 3'h0;
    sequence s_launch; wr_ack && erase_start == rpl_pkg::RPL_ALL_DONE && busy; endsequence
    sequence s_open; access_open && debug_open; endsequence
    chk_req_answer: assert property (go |=> wr_ack != wr_refused) else $error("no single answer");
    chk_lvl2_refuse: assert property (go && l2 && !b2 |=> wr_refused) else $error("no refusal");
    chk_lvl2_hold: assert property (l2 && !boot_load && !$past(boot_load) |=> l2) else $error("left level 2");
    chk_raise_quiet: assert property (go && b2 |=> wr_ack && erase_start == 3'h0 ##1 l2 && !debug_open)
        else $error("raise misbehaved");
    chk_erase_launch: assert property (go && b0 && !l2 |=> s_launch) else $error("no erase");
    chk_closed_busy: assert property (busy || $fell(busy) |-> !access_open && !debug_open)
        else $error("open while erasing");
    chk_erase_wait: assert property (busy && !fin |=> busy) else $error("erase ended early");
    chk_lvl0_apply: assert property ($fell(busy) |-> level == rpl_pkg::RPL_LVL0 &&
        read_protect_option == rpl_pkg::RPL_BYTE_LVL0 ##1 s_open) else $error("level 0 not applied");
endmodule
bind rpl_control rpl_props rpl_props_inst (.*);
`default_nettype wire

//--- testbench/rpl_mem_model.sv
// erase responder for eeprom, flash and backup memories
// each memory reports done a bench-set delay, lengthened by its index, after its start pulse
`timescale 1ns/1ps
`default_nettype none
module rpl_mem_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] erase_start,
    input wire logic [7:0] dly,
    output logic [2:0] erase_done
);
    logic [7:0] cnt_q [3];
    always_ff @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            erase_done[i] <= !sys_rst && cnt_q[i] == 8'h01;
            cnt_q[i] <= sys_rst ? 8'h00 : erase_start[i] ? dly + 8'(i) : cnt_q[i] - 8'(cnt_q[i] != 8'h00);
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for rpl_control with the erase responder
// one clock, reset held five cycles, inputs driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 0, sys_rst = 1, boot_load = 0, wr_req = 0, wr_ack, wr_refused, busy, access_open, debug_open;
    logic [7:0] boot_byte = 8'h00, wr_byte = 8'h00, read_protect_option, dly = 8'h01, b;
    logic [2:0] erase_done, erase_start;
    logic [1:0] level, lvl = 2'h1;
    int failures = 0, n_tests = 0;
    bit hung = 1'b0;
    logic [7:0] opt = 8'h55;
    logic [7:0] tbl [8] = '{8'haa, 8'haa, 8'h55, 8'hcc, 8'haa, 8'h55, 8'hcc, 8'h55};
    rpl_control rpl_control_inst (.*);
    rpl_mem_model rpl_mem_model_inst (.*);
    initial forever #4 clock = ~clock;
    function automatic logic [1:0] dec(input logic [7:0] v);
        return v == 8'haa ? 2'h0 : v == 8'hcc ? 2'h2 : 2'h1;
    endfunction
    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    // boot loads the byte directly; a write goes through the level rules
    task automatic req(input logic [7:0] v, input logic boot);
        logic [7:0] o;
        logic [1:0] e;
        logic r;
        int k;
        r = lvl == 2'h2 && !boot && v != 8'hcc;
        o = r ? opt : v;
        e = dec(o);
        {wr_req, boot_load, wr_byte, boot_byte} = {!boot, boot, v, v};
        @(negedge clock);
        {wr_req, boot_load} = 2'b00;
        if (!boot) begin
            chk("refused", 8'(wr_refused), 8'(r));
            chk("ack", 8'(wr_ack), 8'(!r));
            chk("erase", 8'(erase_start), (v == 8'haa && !r) ? 8'h07 : 8'h00);
            chk("busy", 8'(busy), 8'(v == 8'haa && !r));
        end
        for (k = 0; busy !== 1'b0 && k < 99; k++) @(negedge clock);
        if (k == 99) begin
            failures++;
            hung = 1'b1;
            return;
        end
        repeat (2) @(negedge clock);
        chk("level", 8'(level), 8'(e));
        chk("option", read_protect_option, o);
        chk("open", 8'({access_open, debug_open}), 8'({e == 2'h0, e != 2'h2}));
        lvl = e;
        opt = o;
    endtask
    initial begin
        void'($urandom(32'h3772_edbb));
        repeat (5) @(negedge clock);
        sys_rst = 0;
        @(negedge clock);
        chk("reset", read_protect_option, 8'h55);
        chk("reset_open", 8'({access_open, debug_open, level}), 8'h05);
        for (int i = 0; i < 48; i++) begin
            b = i < 8 ? tbl[i] : ($urandom_range(3) == 0 ? 8'($urandom) : tbl[$urandom_range(3)]);
            dly = 8'($urandom_range(12, 1));
            if (i >= 8 && b == 8'haa && level === 2'h0) b = 8'h55;
            req(b, i == 7 || (i > 7 && lvl == 2'h2 && $urandom_range(3) == 0));
            $display("test %0d done", i);
            if (hung) break;
        end
        test_done();
    end
endmodule
`default_nettype wire
